// File: sbpa_pkg.sv
package sbpa_pkg;

  // Clock rate and reconnect window
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned RECON_TMO_US     = 1000000;
  localparam int unsigned RECON_TMO_CYC    = RECON_TMO_US * CLK_MHZ;

  // Unit directory keys and field values
  localparam logic [7:0]  KEY_SPEC_OWNER   = 8'h38;
  localparam logic [7:0]  KEY_PROTO_FAMILY = 8'h39;
  localparam logic [7:0]  KEY_UNIT_TYPE    = 8'h14;
  localparam logic [4:0]  UNIT_CLASS_BLOCK = 5'h0e;
  localparam logic [15:0] UNIT_INDEX_ONLY  = 16'h0000;
  localparam logic [1:0]  ROM_IDX_OWNER    = 2'h0;
  localparam logic [1:0]  ROM_IDX_FAMILY   = 2'h1;
  localparam logic [1:0]  ROM_IDX_UNIT     = 2'h2;
  localparam logic [31:0] ROM_RESET        = 32'h0000_0000;

  // Management function codes
  localparam logic [3:0]  MF_LOGIN         = 4'h0;
  localparam logic [3:0]  MF_RECONNECT     = 4'h3;
  localparam logic [3:0]  MF_LOGOUT        = 4'h7;

  // Response and transport status codes
  localparam logic [1:0]  RESPONSE_STATUS_FIELD_COMPLETE    = 2'h0;
  localparam logic [7:0]  TS_OK            = 8'h00;
  localparam logic [7:0]  TS_ID_UNKNOWN    = 8'h0a;
  localparam logic [7:0]  TS_REJECTED      = 8'h04;

  // Status block length field and quadlet counts
  localparam logic [2:0]  LEN_NORMAL       = 3'h1;
  localparam logic [2:0]  LEN_EXCEPTION    = 3'h2;
  localparam logic [2:0]  QUADS_NORMAL     = 3'h2;
  localparam logic [2:0]  QUADS_EXCEPTION  = 3'h4;

  // Inquiry data constants
  localparam logic [7:0]  VPD_SERIAL_PAGE  = 8'h80;

  // Status block handed to the block writer
  typedef struct packed {
    logic       unsol;
    logic [2:0] len;
    logic [2:0] quads;
    logic [1:0] response_status_field;
    logic [7:0] transport_status_field;
    logic [7:0] sense;
  } sbpa_status_t;

  // Management answer
  typedef struct packed {
    logic [1:0] response_status_field;
    logic [7:0] transport_status_field;
  } sbpa_mgmt_ans_t;

endpackage

// File: sbpa_ua_queue.sv
`timescale 1ns/100ps
`default_nettype none
module sbpa_ua_queue #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 4,
  parameter int unsigned AW    = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Control
  input  wire logic         flush,
  input  wire logic         push,
  input  wire logic [W-1:0] push_data,
  input  wire logic         pop,
  // State
  output logic [W-1:0]      head,
  output logic              not_empty,
  output logic              full
);

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;

  // Next pointers; a push in the flush cycle still lands after the flush
  always_comb begin
    mem_d = mem_q;
    wp_d  = flush ? '0 : wp_q;
    rp_d  = flush ? '0 : rp_q;
    cnt_d = flush ? '0 : cnt_q;
    if (pop && !flush && cnt_q != '0) begin
      rp_d  = rp_q + 1'b1;
      cnt_d = cnt_d - 1'b1;
    end
    if (push && (flush || !full)) begin
      mem_d[wp_d] = push_data;
      wp_d        = wp_d + 1'b1;
      cnt_d       = cnt_d + 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end

  assign head      = mem_q[rp_q];
  assign not_empty = (cnt_q != '0);
  assign full      = (cnt_q == (AW+1)'(DEPTH));

endmodule
`default_nettype wire

// File: sbpa_timer.sv
`timescale 1ns/100ps
`default_nettype none
module sbpa_timer #(
  parameter int unsigned CYC = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Control
  input  wire logic start,
  input  wire logic stop,
  // One-cycle pulse when the window runs out
  output logic      expired
);

  localparam int unsigned CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic          exp_d, exp_q;

  // Count down while armed; stop wins over start
  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (stop) begin
      cnt_d = '0;
    end else if (start) begin
      cnt_d = CW'(CYC);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
      exp_d = (cnt_q == CW'(1));
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;

endmodule
`default_nettype wire

// File: sbpa_agent.sv
// Functional notes
// - Power reset drops login and returns agents to reset state.
// - Reconnect after power reset answers response 0, transport status Ah.
// - After bus reset, reconnect restores the existing login.
// - Unit directory holds key 38h entry naming command set owner.
// - Unit directory holds key 39h entry naming the command set.
// - Key 14h entry carries device class and logical unit index.
// - Device class field reads 0Eh.
// - Single logical unit reports index 0000h.
// - Master password is offered through inquiry page 80h serial number.
// - Clean completion writes two quadlets with length field 1.
// - Exception status writes four quadlets with length field 2.
// - Inquiry data reports async event capability bit as one.
// - Unsolicited status starts disabled; sent only after arm write.
// - Each unsolicited status consumes arming; host must rearm.
// - Unit attention stays until delivered or login ends.
// - Several unit attentions queue instead of overwriting.
// - Bus reset keeps undelivered event status for logged-in host.
// - Missing reconnect within timeout discards retained event status.
// - After reconnect and arm write, retained status goes out unsolicited.
// - Delivered retained status is cleared.
// - Every executed command gets a status block, notify ignored.
`timescale 1ns/100ps
`default_nettype none
module sbpa_agent #(
  parameter int unsigned   RECON_CYC  = sbpa_pkg::RECON_TMO_CYC,
  parameter int unsigned   UA_DEPTH   = 4,
  parameter int unsigned   UA_AW      = 2,
  parameter logic [23:0]   SPEC_OWNER = 24'h12_3456, // Arbitrary value
  parameter logic [23:0]   PROTO_FAM  = 24'h65_4321  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // Reset events
  input  wire logic                power_reset,
  input  wire logic                bus_reset,
  // Management requests
  input  wire logic                mgmt_req,
  input  wire logic [3:0]          mgmt_func,
  output logic                     mgmt_done_q,
  output sbpa_pkg::sbpa_mgmt_ans_t mgmt_ans_q,
  // Unsolicited status arm write
  input  wire logic                arm_wr,
  // Unit attention events
  input  wire logic                ua_event,
  input  wire logic [7:0]          ua_sense,
  // Command completions
  input  wire logic                cmd_done,
  input  wire logic                cmd_exc,
  input  wire logic [7:0]          cmd_sense,
  output logic                     cmd_ready_q,
  // Status block writer
  output logic                     st_req_q,
  output sbpa_pkg::sbpa_status_t   st_blk_q,
  input  wire logic                st_ack,
  input  wire logic                st_good,
  // Configuration ROM entries
  input  wire logic [1:0]          rom_idx,
  output logic [31:0]              rom_data_q,
  // Inquiry data
  output logic                     inq_async_event_capability_bit_q,
  output logic [7:0]               inq_serial_page_q,
  // State
  output logic                     logged_in_q,
  output logic                     arm_q
);
  typedef enum logic [1:0] {
    LS_RESET = 2'b00,
    LS_LOGGED = 2'b01,
    LS_RECON_WAIT = 2'b10
  } sbpa_login_t;
  typedef enum logic {
    WS_IDLE = 1'b0,
    WS_BUSY = 1'b1
  } sbpa_wr_t;

  sbpa_login_t              lst_q, lst_d;
  sbpa_wr_t                 wst_q, wst_d;
  logic                     done_d, arm_d, req_d, cpend_q, cpend_d;
  sbpa_pkg::sbpa_mgmt_ans_t ans_d;
  sbpa_pkg::sbpa_status_t   blk_d, cblk_q, cblk_d;
  logic [31:0]              rom_d;
  logic                     flush, tstart, tstop, expired, ua_pop;
  logic                     ua_ne, ua_full, issue_cmd, issue_unsol;
  logic [7:0]               ua_head;

  // Length field for a status block
  function automatic logic [2:0] blk_len(input logic exc);
    return exc ? sbpa_pkg::LEN_EXCEPTION : sbpa_pkg::LEN_NORMAL;
  endfunction
  // Quadlets written for a status block
  function automatic logic [2:0] blk_quads(input logic exc);
    return exc ? sbpa_pkg::QUADS_EXCEPTION : sbpa_pkg::QUADS_NORMAL;
  endfunction

  sbpa_ua_queue #(
    .W     (8),
    .DEPTH (UA_DEPTH),
    .AW    (UA_AW)
  ) u_ua_queue (
    .clk       (clk),
    .srst      (srst),
    .flush     (flush),
    .push      (ua_event),
    .push_data (ua_sense),
    .pop       (ua_pop),
    .head      (ua_head),
    .not_empty (ua_ne),
    .full      (ua_full)
  );

  // Reconnect window after a bus reset
  sbpa_timer #(
    .CYC (RECON_CYC)
  ) u_recon_timer (
    .clk     (clk),
    .srst    (srst),
    .start   (tstart),
    .stop    (tstop),
    .expired (expired)
  );
  // Login state and management answers; reset events outrank requests
  always_comb begin
    lst_d  = lst_q;
    done_d = 1'b0;
    ans_d  = mgmt_ans_q;
    flush  = 1'b0;
    tstart = 1'b0;
    tstop  = 1'b0;
    if (power_reset) begin
      lst_d = LS_RESET;
      flush = 1'b1;
      tstop = 1'b1;
    end else if (bus_reset) begin
      if (lst_q != LS_RESET) begin
        lst_d  = LS_RECON_WAIT;
        tstart = 1'b1;
      end
    end else if (expired && lst_q == LS_RECON_WAIT) begin
      lst_d = LS_RESET;
      flush = 1'b1;
    end else if (mgmt_req) begin
      done_d = 1'b1;
      ans_d.response_status_field  = sbpa_pkg::RESPONSE_STATUS_FIELD_COMPLETE;
      ans_d.transport_status_field = sbpa_pkg::TS_OK;
      unique case (mgmt_func)
        sbpa_pkg::MF_LOGIN: begin
          if (lst_q == LS_RESET) begin
            lst_d = LS_LOGGED;
          end else begin
            ans_d.transport_status_field = sbpa_pkg::TS_REJECTED;
          end
        end
        sbpa_pkg::MF_RECONNECT: begin
          if (lst_q == LS_RECON_WAIT) begin
            lst_d = LS_LOGGED;
            tstop = 1'b1;
          end else begin
            ans_d.transport_status_field = sbpa_pkg::TS_ID_UNKNOWN;
          end
        end
        sbpa_pkg::MF_LOGOUT: begin
          if (lst_q == LS_LOGGED) begin
            lst_d = LS_RESET;
            flush = 1'b1;
          end else begin
            ans_d.transport_status_field = sbpa_pkg::TS_ID_UNKNOWN;
          end
        end
        default: begin
          ans_d.transport_status_field = sbpa_pkg::TS_REJECTED;
        end
      endcase
    end
  end
  // Writer issue decisions; command status goes first since it gates the queue of orbs
  assign issue_cmd   = (wst_q == WS_IDLE) && cpend_q;
  assign issue_unsol = (wst_q == WS_IDLE) && !cpend_q && arm_q && ua_ne &&
                       (lst_q == LS_LOGGED) && !flush;

  // Arm flag, command holding slot and block writer
  always_comb begin
    arm_d   = arm_q;
    cpend_d = cpend_q;
    cblk_d  = cblk_q;
    wst_d   = wst_q;
    req_d   = st_req_q;
    blk_d   = st_blk_q;
    ua_pop  = 1'b0;
    if (issue_unsol) begin
      arm_d = 1'b0;
    end
    // arm write enables delivery after reconnect
    if (arm_wr && lst_q == LS_LOGGED) begin
      arm_d = 1'b1;
    end
    if (power_reset || bus_reset) begin
      arm_d = 1'b0;
    end
    if (issue_cmd) begin
      cpend_d = 1'b0;
    end
    if (cmd_done && !cpend_q) begin
      cpend_d = 1'b1;
      cblk_d  = '{1'b0, blk_len(cmd_exc), blk_quads(cmd_exc), sbpa_pkg::RESPONSE_STATUS_FIELD_COMPLETE,
                  sbpa_pkg::TS_OK, cmd_sense};
    end
    unique case (wst_q)
      WS_IDLE: begin
        if (issue_cmd) begin
          blk_d = cblk_q;
          req_d = 1'b1;
          wst_d = WS_BUSY;
        end else if (issue_unsol) begin
          blk_d = '{1'b1, blk_len(1'b1), blk_quads(1'b1), sbpa_pkg::RESPONSE_STATUS_FIELD_COMPLETE,
                    sbpa_pkg::TS_OK, ua_head};
          req_d = 1'b1;
          wst_d = WS_BUSY;
        end
      end
      WS_BUSY: begin
        if (st_ack) begin
          req_d = 1'b0;
          wst_d = WS_IDLE;
          ua_pop = st_blk_q.unsol && st_good;
        end
      end
    endcase
  end

  // Constant identification entries
  always_comb begin
    unique case (rom_idx)
      sbpa_pkg::ROM_IDX_OWNER:  rom_d = {sbpa_pkg::KEY_SPEC_OWNER, SPEC_OWNER};
      sbpa_pkg::ROM_IDX_FAMILY: rom_d = {sbpa_pkg::KEY_PROTO_FAMILY, PROTO_FAM};
      sbpa_pkg::ROM_IDX_UNIT:   rom_d = {sbpa_pkg::KEY_UNIT_TYPE, 3'h0,
                                         sbpa_pkg::UNIT_CLASS_BLOCK,
                                         sbpa_pkg::UNIT_INDEX_ONLY};
      default:                  rom_d = sbpa_pkg::ROM_RESET;
    endcase
  end

  // Register stage for all groups
  always_ff @(posedge clk) begin
    if (srst) begin
      lst_q             <= LS_RESET;
      wst_q             <= WS_IDLE;
      mgmt_done_q       <= 1'b0;
      mgmt_ans_q        <= '0;
      arm_q             <= 1'b0;
      cpend_q           <= 1'b0;
      cblk_q            <= '0;
      st_req_q          <= 1'b0;
      st_blk_q          <= '0;
      rom_data_q        <= sbpa_pkg::ROM_RESET;
      inq_async_event_capability_bit_q        <= 1'b0;
      inq_serial_page_q <= 8'h00;
      logged_in_q       <= 1'b0;
      cmd_ready_q       <= 1'b0;
    end else begin
      lst_q             <= lst_d;
      wst_q             <= wst_d;
      mgmt_done_q       <= done_d;
      mgmt_ans_q        <= ans_d;
      arm_q             <= arm_d;
      cpend_q           <= cpend_d;
      cblk_q            <= cblk_d;
      st_req_q          <= req_d;
      st_blk_q          <= blk_d;
      rom_data_q        <= rom_d;
      inq_async_event_capability_bit_q        <= 1'b1;
      inq_serial_page_q <= sbpa_pkg::VPD_SERIAL_PAGE;
      logged_in_q       <= (lst_d == LS_LOGGED);
      cmd_ready_q       <= !cpend_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_unsol_sent;
    issue_unsol ##1 st_req_q && st_blk_q.unsol;
  endsequence
  pwr_drop_a: assert property (power_reset |=> lst_q == LS_RESET &&
      (!ua_ne || $past(ua_event)))
    else $error("power reset left a login or attention");
  recon_unknown_a: assert property (mgmt_req && !power_reset && !bus_reset && !expired &&
      mgmt_func == sbpa_pkg::MF_RECONNECT && lst_q == LS_RESET |=> mgmt_done_q &&
      mgmt_ans_q.response_status_field == 2'h0 && mgmt_ans_q.transport_status_field == 8'h0a)
    else $error("reconnect after power reset not rejected");
  recon_restore_a: assert property (mgmt_req && !power_reset && !bus_reset && !expired &&
      mgmt_func == sbpa_pkg::MF_RECONNECT && lst_q == LS_RECON_WAIT |=>
      logged_in_q && mgmt_ans_q.transport_status_field == 8'h00)
    else $error("reconnect did not restore login");
  unit_entry_a: assert property (rom_idx == 2'h2 |=> rom_data_q == 32'h140e_0000)
    else $error("unit type entry wrong");
  clean_len_a: assert property (issue_cmd && !cblk_q.unsol && cblk_q.len == 3'h1 |=>
      st_req_q && st_blk_q.quads == 3'h2)
    else $error("clean status block size wrong");
  unsol_arm_a: assert property (s_unsol_sent |->
      $past(arm_q) && (!arm_q || $past(arm_wr)))
    else $error("unsolicited status without arming");
  exc_len_a: assert property (s_unsol_sent |-> st_blk_q.len == 3'h2 &&
      st_blk_q.quads == 3'h4)
    else $error("unsolicited block size wrong");
  ua_hold_a: assert property (wst_q == WS_BUSY && st_ack && !st_good && !flush |=>
      ua_ne || !$past(ua_ne))
    else $error("attention lost on failed write");
  bus_keep_a: assert property (bus_reset && !power_reset && ua_ne |=> ua_ne [*2])
    else $error("bus reset dropped event status");
  tmo_drop_a: assert property (expired && !power_reset && !bus_reset &&
      lst_q == LS_RECON_WAIT |=> lst_q == LS_RESET && (!ua_ne || $past(ua_event)))
    else $error("timeout kept event status");

endmodule
`default_nettype wire

// File: sbpa_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Initiator memory side: completes each status block write after a delay
module sbpa_host_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Status block write from the device
  input  wire logic       st_req_q,
  // Test controls
  input  wire logic       fail_next,
  input  wire logic [1:0] ack_dly,
  // Write completion
  output logic            st_ack,
  output logic            st_good
);
  logic [1:0] state_q;
  logic [1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= 2'h0;
      cnt_q   <= 2'h0;
      st_ack  <= 1'b0;
      st_good <= 1'b0;
    end else begin
      st_ack  <= 1'b0;
      st_good <= ~st_good; // Response level toggles every cycle between acks
      case (state_q)
        2'h0: if (st_req_q) begin
          cnt_q   <= ack_dly;
          state_q <= 2'h1;
        end
        2'h1: if (cnt_q == 2'h0) begin
          st_ack  <= 1'b1;
          st_good <= ~fail_next;
          state_q <= 2'h2;
        end else begin
          cnt_q <= cnt_q - 2'h1;
        end
        // Request stands one cycle past the ack, so wait for it to drop
        default: if (!st_req_q) begin
          state_q <= 2'h0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: test_serial_bus_login_status_agent.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_serial_bus_login_status_agent;
  localparam logic [23:0] OWNER = 24'h0a_bcde; // Arbitrary value
  localparam logic [23:0] FAM   = 24'h05_a5a5; // Arbitrary value
  logic clk, srst, power_reset, bus_reset, mgmt_req, arm_wr, ua_event;
  logic cmd_done, cmd_exc, st_ack, st_good, fail_next, req_seen;
  logic [3:0] mgmt_func;
  logic [7:0] ua_sense, cmd_sense;
  logic [1:0] rom_idx, ack_dly;
  logic mgmt_done_q, cmd_ready_q, st_req_q, inq_async_event_capability_bit_q, logged_in_q, arm_q;
  sbpa_pkg::sbpa_mgmt_ans_t mgmt_ans_q, mg_got;
  sbpa_pkg::sbpa_status_t   st_blk_q, st_got;
  logic [31:0] rom_data_q, rnd;
  logic [7:0]  inq_serial_page_q, s1, s2;
  sbpa_pkg::sbpa_mgmt_ans_t exp_mg[$];
  sbpa_pkg::sbpa_status_t   exp_st[$];
  int errors, comparisons, cycles;

  sbpa_agent #(.RECON_CYC(20), .SPEC_OWNER(OWNER), .PROTO_FAM(FAM)) i_sbpa_agent (
    .clk(clk), .srst(srst), .power_reset(power_reset), .bus_reset(bus_reset),
    .mgmt_req(mgmt_req), .mgmt_func(mgmt_func), .mgmt_done_q(mgmt_done_q),
    .mgmt_ans_q(mgmt_ans_q), .arm_wr(arm_wr), .ua_event(ua_event), .ua_sense(ua_sense),
    .cmd_done(cmd_done), .cmd_exc(cmd_exc), .cmd_sense(cmd_sense),
    .cmd_ready_q(cmd_ready_q), .st_req_q(st_req_q), .st_blk_q(st_blk_q), .st_ack(st_ack),
    .st_good(st_good), .rom_idx(rom_idx), .rom_data_q(rom_data_q), .inq_async_event_capability_bit_q(inq_async_event_capability_bit_q),
    .inq_serial_page_q(inq_serial_page_q), .logged_in_q(logged_in_q), .arm_q(arm_q));
  sbpa_host_model i_sbpa_host_model (
    .clk(clk), .srst(srst), .st_req_q(st_req_q), .fail_next(fail_next),
    .ack_dly(ack_dly), .st_ack(st_ack), .st_good(st_good));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic sbpa_pkg::sbpa_status_t blk(input logic u, input logic e,
                                                 input logic [7:0] sn);
    return {u, e ? sbpa_pkg::LEN_EXCEPTION : sbpa_pkg::LEN_NORMAL,
            e ? sbpa_pkg::QUADS_EXCEPTION : sbpa_pkg::QUADS_NORMAL,
            sbpa_pkg::RESPONSE_STATUS_FIELD_COMPLETE, sbpa_pkg::TS_OK, sn};
  endfunction

  task automatic close_out();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      close_out();
    end
  end

  // Watcher: each answer or new status block is matched against the oldest note
  always @(negedge clk) begin
    if (!srst) begin
      if (mgmt_done_q === 1'b1) begin
        if (exp_mg.size() == 0) `CHK(1'b1, 1'b0)
        else begin
          mg_got = exp_mg.pop_front();
          `CHK(mgmt_ans_q, mg_got)
        end
      end
      if (st_req_q === 1'b1 && !req_seen) begin
        if (exp_st.size() == 0) `CHK(1'b1, 1'b0)
        else begin
          st_got = exp_st.pop_front();
          `CHK(st_blk_q, st_got)
        end
      end
      req_seen = (st_req_q === 1'b1);
    end
  end

  task automatic mgmt(input logic [3:0] f, input logic [7:0] ts);
    exp_mg.push_back({sbpa_pkg::RESPONSE_STATUS_FIELD_COMPLETE, ts});
    mgmt_req  = 1'b1;
    mgmt_func = f;
    @(negedge clk) mgmt_req = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // Let any block in flight finish before the next step
  task automatic idle();
    int n;
    n = 0;
    repeat (3) @(negedge clk);
    while (st_req_q !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    rnd     = xs(rnd);
    ack_dly = rnd[1:0];
    s = 1'b1;
    @(negedge clk) s = 1'b0;
    @(negedge clk); // Gap so a following strobe never rises in the same step
  endtask

  task automatic cmd(input logic e);
    rnd       = xs(rnd);
    cmd_sense = rnd[15:8];
    cmd_exc   = e;
    exp_st.push_back(blk(1'b0, e, rnd[15:8]));
    pulse(cmd_done);
    idle();
  endtask

  task automatic ua(input logic [7:0] sn);
    ua_sense = sn;
    pulse(ua_event);
  endtask

  // Bus reset then reconnect: login restored but disarmed, so a new event stays queued
  task automatic rejoin();
    pulse(bus_reset);
    mgmt(sbpa_pkg::MF_RECONNECT, sbpa_pkg::TS_OK);
  endtask

  initial begin
    {power_reset, bus_reset, mgmt_req, arm_wr, ua_event, cmd_done, cmd_exc} = '0;
    {fail_next, req_seen} = '0;
    {mgmt_func, ua_sense, cmd_sense, rom_idx, ack_dly} = '0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    rnd = 32'h289a;
    srst = 1'b1;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    `CHK(inq_async_event_capability_bit_q, 1'b1)
    `CHK(inq_serial_page_q, sbpa_pkg::VPD_SERIAL_PAGE)
    `CHK(arm_q, 1'b0)
    `CHK(cmd_ready_q, 1'b1)
    // Unit directory entries, all four selects
    for (int i = 0; i < 4; i++) begin
      rom_idx = i[1:0];
      @(negedge clk);
      case (i)
        0: `CHK(rom_data_q, {8'h38, OWNER})
        1: `CHK(rom_data_q, {8'h39, FAM})
        2: `CHK(rom_data_q, {8'h14, 3'h0, 5'h0e, 16'h0000})
        default: `CHK(rom_data_q, 32'h0000_0000)
      endcase
    end
    mgmt(sbpa_pkg::MF_RECONNECT, sbpa_pkg::TS_ID_UNKNOWN);
    mgmt(sbpa_pkg::MF_LOGIN, sbpa_pkg::TS_OK);
    mgmt(sbpa_pkg::MF_LOGIN, sbpa_pkg::TS_REJECTED);
    `CHK(logged_in_q, 1'b1)
    `CHK(inq_serial_page_q, sbpa_pkg::VPD_SERIAL_PAGE)
    mgmt(4'h5, sbpa_pkg::TS_REJECTED);
    cmd(1'b0);
    cmd(1'b1);
    cmd(1'b0);
    rnd = xs(rnd);
    s1  = rnd[7:0];
    s2  = rnd[15:8];
    ua(s1);
    ua(s2);
    idle();
    // failed write keeps the head entry
    fail_next = 1'b1;
    exp_st.push_back(blk(1'b1, 1'b1, s1));
    pulse(arm_wr);
    idle();
    fail_next = 1'b0;
    `CHK(arm_q, 1'b0)
    // host rearms after each unsolicited status
    exp_st.push_back(blk(1'b1, 1'b1, s1));
    pulse(arm_wr);
    idle();
    exp_st.push_back(blk(1'b1, 1'b1, s2));
    pulse(arm_wr);
    idle();
    // Armed with nothing queued: no block may appear
    pulse(arm_wr);
    idle();
    `CHK(arm_q, 1'b1)
    rejoin();
    ua(s2);
    pulse(bus_reset);
    @(negedge clk);
    `CHK(logged_in_q, 1'b0)
    `CHK(arm_q, 1'b0)
    mgmt(sbpa_pkg::MF_RECONNECT, sbpa_pkg::TS_OK);
    `CHK(logged_in_q, 1'b1)
    exp_st.push_back(blk(1'b1, 1'b1, s2));
    pulse(arm_wr);
    idle();
    pulse(arm_wr);
    idle();
    pulse(bus_reset);
    ua(s1);
    repeat (30) @(negedge clk);
    mgmt(sbpa_pkg::MF_LOGIN, sbpa_pkg::TS_OK);
    pulse(arm_wr);
    idle();
    // power reset drops login and queue
    rejoin();
    ua(s1);
    pulse(power_reset);
    @(negedge clk);
    `CHK(logged_in_q, 1'b0)
    mgmt(sbpa_pkg::MF_RECONNECT, sbpa_pkg::TS_ID_UNKNOWN);
    mgmt(sbpa_pkg::MF_LOGIN, sbpa_pkg::TS_OK);
    pulse(arm_wr);
    idle();
    mgmt(sbpa_pkg::MF_LOGOUT, sbpa_pkg::TS_OK);
    mgmt(sbpa_pkg::MF_LOGOUT, sbpa_pkg::TS_ID_UNKNOWN);
    `CHK(exp_st.size(), 0)
    `CHK(exp_mg.size(), 0)
    close_out();
  end
endmodule
`default_nettype wire
